// [pib_irq_bank.sv]
// peripheral interrupt flag and enable bank with wishbone access
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module pib_irq_bank import pib_pkg::*; #(
  parameter int unsigned PORT_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  input  wire logic [PORT_W-1:0] change_monitored_port,
  input  wire logic              port_read_pulse,
  input  wire logic [7:0]        timer1_count,
  input  wire logic [7:0]        timer2_count,
  input  wire logic [15:0]       timer3_count,
  input  wire logic [7:0]        timer1_period_value,
  input  wire logic [7:0]        timer2_period_value,
  input  wire logic [15:0]       timer3_period_value,
  input  wire logic              capture1_pin,
  input  wire logic              capture2_pin,
  input  wire logic              capture3_pin,
  input  wire logic              capture4_pin,
  input  wire logic [7:0]        capture_modes,
  input  wire logic              usart1_tx_empty,
  input  wire logic              usart1_rx_full,
  input  wire logic              usart2_tx_empty,
  input  wire logic              usart2_rx_full,
  input  wire logic              serial_xfer_done,
  input  wire logic              serial_i2c_master,
  input  wire logic              serial_seq_done,
  input  wire logic              serial_idle,
  input  wire logic              serial_bus_start_stop,
  input  wire logic              serial_bus_collision,
  input  wire logic              converter_done,
  output var  logic              timer_pair_select,
  output var  logic              capture1_or_period_select,
  output var  logic              irq_req_r
);
  pib_reg_if rif ();

  logic [DAT_W-1:0]  peripheral_irq_flags_1_r;
  logic [DAT_W-1:0]  peripheral_irq_flags_1_nxt;
  logic [DAT_W-1:0]  peripheral_irq_flags_2_r;
  logic [DAT_W-1:0]  peripheral_irq_flags_2_nxt;
  logic [DAT_W-1:0]  peripheral_irq_enable_1_r;
  logic [DAT_W-1:0]  peripheral_irq_enable_2_r;
  logic [DAT_W-1:0]  set1;
  logic [DAT_W-1:0]  set2;
  logic [PORT_W-1:0] port_sync1_r;
  logic [PORT_W-1:0] port_sync2_r;
  logic [PORT_W-1:0] port_sync3_r;
  logic [PORT_W-1:0] port_stable_r;
  logic [PORT_W-1:0] port_latch_r;
  logic              port_primed_r;
  logic              port_mismatch;
  logic              t1_match_r;
  logic              t2_match_r;
  logic              pair_match_r;
  logic              t3_match_r;
  logic              t3_full_r;
  logic              t1_set;
  logic              t2_set;
  logic              t3_set;
  logic [3:0]        capt_pins;
  logic [3:0]        capt_event;
  logic              serial_set;
  logic              bus_coll_set;

  initial begin
    if (PORT_W < 1 || PORT_W > DAT_W) $error("pib_irq_bank: PORT_W must be 1..8");
  end

  pib_wb_slave u_wb (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rif      (rif)
  );

  // pin inputs pass three stages
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      port_sync1_r <= '0;
      port_sync2_r <= '0;
      port_sync3_r <= '0;
    end else begin
      port_sync1_r <= change_monitored_port;
      port_sync2_r <= port_sync1_r;
      port_sync3_r <= port_sync2_r;
    end
  end

  // per bit: a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      port_stable_r <= '0;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (port_sync2_r[i] == port_sync3_r[i]) begin
          port_stable_r[i] <= port_sync3_r[i];
        end
      end
    end
  end

  // latch the port once after reset, then on every port read
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      port_latch_r  <= '0;
      port_primed_r <= 1'b0;
    end else if (!port_primed_r || port_read_pulse) begin
      port_latch_r  <= port_stable_r;
      port_primed_r <= 1'b1;
    end
  end

  assign port_mismatch = port_primed_r && (port_stable_r != port_latch_r);

  // period and overflow trackers, one cycle behind the counts
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      t1_match_r   <= 1'b0;
      t2_match_r   <= 1'b0;
      pair_match_r <= 1'b0;
      t3_match_r   <= 1'b0;
      t3_full_r    <= 1'b0;
    end else begin
      t1_match_r   <= timer1_count == timer1_period_value;
      t2_match_r   <= timer2_count == timer2_period_value;
      pair_match_r <= {timer2_count, timer1_count} == {timer2_period_value, timer1_period_value};
      t3_match_r   <= timer3_count == timer3_period_value;
      t3_full_r    <= timer3_count == TIMER3_FULL;
    end
  end

  // paired timers use the joined period
  assign t1_set = timer_pair_select
                ? (pair_match_r && ({timer2_count, timer1_count} == 16'h0000))
                : (t1_match_r && (timer1_count == 8'h00));
  assign t2_set = t2_match_r && (timer2_count == 8'h00);
  assign t3_set = (timer3_count == 16'h0000)
                && (capture1_or_period_select ? t3_full_r : t3_match_r);

  assign capt_pins = {capture4_pin, capture3_pin, capture2_pin, capture1_pin};

  // capture3 and capture4 the same way
  for (genvar g = 0; g < 4; g++) begin : g_capt
    pib_capture #(
      .SYNC_N (3)
    ) u_capt (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .pin     (capt_pins[g]),
      .mode    (capture_modes[2*g+1 -: 2]),
      .event_r (capt_event[g])
    );
  end

  // idle start or stop on the bus
  assign serial_set = serial_xfer_done
                    || (serial_i2c_master && serial_seq_done)
                    || (serial_idle && serial_bus_start_stop);
  assign bus_coll_set = serial_i2c_master && serial_bus_collision;

  always_comb begin
    set1 = 8'h00;
    set1[B_PORT_CHG] = port_mismatch;
    set1[B_TIMER3]   = t3_set;
    set1[B_TIMER2]   = t2_set;
    set1[B_TIMER1]   = t1_set;
    set1[B_CAPT2]    = capt_event[1];
    set1[B_CAPT1]    = capt_event[0];
    set2 = 8'h00;
    set2[B_SERIAL]   = serial_set;
    set2[B_BUS_COLL] = bus_coll_set;
    set2[B_CONV]     = converter_done;
    set2[B_CAPT4]    = capt_event[3];
    set2[B_CAPT3]    = capt_event[2];
  end

  // write stores, then hardware sets override a clear
  always_comb begin
    peripheral_irq_flags_1_nxt = peripheral_irq_flags_1_r;
    if (rif.wr && rif.idx == IDX_FLAGS1) begin
      peripheral_irq_flags_1_nxt = (peripheral_irq_flags_1_r & ~FLAGS1_SW_MASK)
                                 | (rif.wdata & FLAGS1_SW_MASK);
    end
    peripheral_irq_flags_1_nxt = peripheral_irq_flags_1_nxt | set1;
    peripheral_irq_flags_1_nxt[B_U1_TX] = usart1_tx_empty;
    peripheral_irq_flags_1_nxt[B_U1_RX] = usart1_rx_full;
  end

  // same policy on the second bank
  always_comb begin
    peripheral_irq_flags_2_nxt = peripheral_irq_flags_2_r;
    if (rif.wr && rif.idx == IDX_FLAGS2) begin
      peripheral_irq_flags_2_nxt = (peripheral_irq_flags_2_r & ~FLAGS2_SW_MASK)
                                 | (rif.wdata & FLAGS2_SW_MASK);
    end
    peripheral_irq_flags_2_nxt = peripheral_irq_flags_2_nxt | set2;
    peripheral_irq_flags_2_nxt[B_U2_TX] = usart2_tx_empty;
    peripheral_irq_flags_2_nxt[B_U2_RX] = usart2_rx_full;
    peripheral_irq_flags_2_nxt[B_UNUSED] = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      peripheral_irq_flags_1_r <= FLAGS1_RST;
      peripheral_irq_flags_2_r <= FLAGS2_RST;
    end else begin
      peripheral_irq_flags_1_r <= peripheral_irq_flags_1_nxt;
      peripheral_irq_flags_2_r <= peripheral_irq_flags_2_nxt;
    end
  end

  // enable bits, bit 4 of the second enable masked off
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      peripheral_irq_enable_1_r <= ENABLE_RST;
      peripheral_irq_enable_2_r <= ENABLE_RST;
    end else if (rif.wr) begin
      if (rif.idx == IDX_ENABLE1) begin
        peripheral_irq_enable_1_r <= rif.wdata & ENABLE1_MASK;
      end
      if (rif.idx == IDX_ENABLE2) begin
        peripheral_irq_enable_2_r <= rif.wdata & ENABLE2_MASK;
      end
    end
  end

  // mode selects steer the timer flag qualification
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timer_pair_select         <= CTRL_RST[B_PAIR_SEL];
      capture1_or_period_select <= CTRL_RST[B_CAP1_SEL];
    end else if (rif.wr && rif.idx == IDX_CTRL) begin
      timer_pair_select         <= rif.wdata[B_PAIR_SEL];
      capture1_or_period_select <= rif.wdata[B_CAP1_SEL];
    end
  end

  // request from any enabled flag; one cycle behind the flags
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_req_r <= 1'b0;
    end else begin
      irq_req_r <= |({peripheral_irq_flags_1_r, peripheral_irq_flags_2_r}
                   & {peripheral_irq_enable_1_r, peripheral_irq_enable_2_r});
    end
  end

  // read mux; unmapped indices answer zero
  always_comb begin
    unique case (rif.idx)
      IDX_FLAGS1:  rif.rdata = peripheral_irq_flags_1_r;
      IDX_FLAGS2:  rif.rdata = peripheral_irq_flags_2_r;
      IDX_ENABLE1: rif.rdata = peripheral_irq_enable_1_r;
      IDX_ENABLE2: rif.rdata = peripheral_irq_enable_2_r;
      IDX_CTRL:    rif.rdata = {6'h00, capture1_or_period_select, timer_pair_select};
      default:     rif.rdata = 8'h00;
    endcase
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_unused_bit_zero: assert property (
    !peripheral_irq_flags_2_r[B_UNUSED] && !peripheral_irq_enable_2_r[B_UNUSED])
    else $error("bit 4 of flags2 or enable2 not zero");

  a_enable2_write: assert property (
    rif.wr && rif.idx == IDX_ENABLE2 |=> peripheral_irq_enable_2_r == ($past(rif.wdata) & ENABLE2_MASK))
    else $error("enable2 did not take written value");

  a_port_change_set: assert property (
    port_primed_r && port_stable_r != port_latch_r |=> peripheral_irq_flags_1_r[B_PORT_CHG])
    else $error("port change flag missed a mismatch");

  a_timer3_overflow: assert property (
    capture1_or_period_select && timer3_count == 16'hFFFF ##1
    capture1_or_period_select && timer3_count == 16'h0000 |=> peripheral_irq_flags_1_r[B_TIMER3])
    else $error("timer3 overflow not flagged");

  a_timer2_rollover: assert property (
    timer2_count == timer2_period_value ##1 timer2_count == 8'h00 |=> peripheral_irq_flags_1_r[B_TIMER2])
    else $error("timer2 rollover not flagged");

  a_pair_rollover: assert property (
    timer_pair_select && {timer2_count, timer1_count} == {timer2_period_value, timer1_period_value} ##1
    timer_pair_select && {timer2_count, timer1_count} == 16'h0000 |=> peripheral_irq_flags_1_r[B_TIMER1])
    else $error("paired timer rollover not flagged");

  a_usart1_tx_level: assert property (
    ##1 peripheral_irq_flags_1_r[B_U1_TX] == $past(usart1_tx_empty))
    else $error("usart1 transmit flag does not follow buffer");

  a_set_beats_clear: assert property (
    converter_done && rif.wr && rif.idx == IDX_FLAGS2 && !rif.wdata[B_CONV]
    |=> peripheral_irq_flags_2_r[B_CONV])
    else $error("converter flag lost to a same-cycle clear");

  a_collision_master: assert property (
    serial_bus_collision && serial_i2c_master |=> peripheral_irq_flags_2_r[B_BUS_COLL])
    else $error("bus collision not flagged");

  a_irq_from_flags: assert property (
    |(peripheral_irq_flags_2_r & peripheral_irq_enable_2_r) |=> irq_req_r)
    else $error("enabled flag did not raise request");
endmodule
`default_nettype wire

// [pib_pkg.sv]
// constants for the peripheral interrupt flag bank
package pib_pkg;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned DAT_W = 8;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS2  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_ENABLE2 = 6'h11;
  localparam logic [IDX_W-1:0] IDX_FLAGS1  = 6'h16;
  localparam logic [IDX_W-1:0] IDX_ENABLE1 = 6'h20;
  localparam logic [IDX_W-1:0] IDX_CTRL    = 6'h21;
  // first flag register fields
  localparam int unsigned B_PORT_CHG = 7;
  localparam int unsigned B_TIMER3   = 6;
  localparam int unsigned B_TIMER2   = 5;
  localparam int unsigned B_TIMER1   = 4;
  localparam int unsigned B_CAPT2    = 3;
  localparam int unsigned B_CAPT1    = 2;
  localparam int unsigned B_U1_TX    = 1;
  localparam int unsigned B_U1_RX    = 0;
  // second flag and enable register fields
  localparam int unsigned B_SERIAL   = 7;
  localparam int unsigned B_BUS_COLL = 6;
  localparam int unsigned B_CONV     = 5;
  localparam int unsigned B_UNUSED   = 4;
  localparam int unsigned B_CAPT4    = 3;
  localparam int unsigned B_CAPT3    = 2;
  localparam int unsigned B_U2_TX    = 1;
  localparam int unsigned B_U2_RX    = 0;
  // control register fields
  localparam int unsigned B_PAIR_SEL = 0;
  localparam int unsigned B_CAP1_SEL = 1;
  // software-writable masks
  localparam logic [DAT_W-1:0] FLAGS1_SW_MASK  = 8'hFC;
  localparam logic [DAT_W-1:0] FLAGS2_SW_MASK  = 8'hEC;
  localparam logic [DAT_W-1:0] ENABLE1_MASK    = 8'hFF;
  localparam logic [DAT_W-1:0] ENABLE2_MASK    = 8'hEF;
  localparam logic [DAT_W-1:0] CTRL_MASK       = 8'h03;
  // values after reset
  localparam logic [DAT_W-1:0] FLAGS1_RST  = 8'h02;
  localparam logic [DAT_W-1:0] FLAGS2_RST  = 8'h02;
  localparam logic [DAT_W-1:0] ENABLE_RST  = 8'h00;
  localparam logic [DAT_W-1:0] CTRL_RST    = 8'h00;
  // capture prescale counts and the timer3 full count
  localparam logic [3:0] CAPT_DIV4_LAST  = 4'h3;
  localparam logic [3:0] CAPT_DIV16_LAST = 4'hF;
  localparam logic [15:0] TIMER3_FULL    = 16'hFFFF;
endpackage

// [pib_reg_if.sv]
// register access carrier between bus slave and register bank
`timescale 1ns/1ns
`default_nettype none
interface pib_reg_if;
  import pib_pkg::*;
  logic             wr;
  logic             rd;
  logic [IDX_W-1:0] idx;
  logic [DAT_W-1:0] wdata;
  logic [DAT_W-1:0] rdata;
  modport bus  (output wr, output rd, output idx, output wdata, input rdata);
  modport regs (input wr, input rd, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// [pib_capture.sv]
// capture pin synchroniser, edge select and prescaler
`timescale 1ns/1ns
`default_nettype none
module pib_capture import pib_pkg::*; #(
  parameter int unsigned SYNC_N = 3
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  output var  logic       event_r
);
  logic [SYNC_N-1:0] sync_r;
  logic              stable_r;
  logic [3:0]        rise_cnt_r;
  logic              rise;
  logic              fall;

  initial begin
    if (SYNC_N != 3) $error("pib_capture: SYNC_N must be 3");
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[SYNC_N-2:0], pin};
    end
  end

  // a level counts only once the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stable_r <= 1'b0;
    end else if (sync_r[2] == sync_r[1]) begin
      stable_r <= sync_r[2];
    end
  end

  assign rise = (sync_r[2] == sync_r[1]) && sync_r[2] && !stable_r;
  assign fall = (sync_r[2] == sync_r[1]) && !sync_r[2] && stable_r;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rise_cnt_r <= 4'h0;
    end else if (rise) begin
      rise_cnt_r <= rise_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      event_r <= 1'b0;
    end else begin
      unique case (mode)
        2'h0: event_r <= fall;
        2'h1: event_r <= rise;
        2'h2: event_r <= rise && (rise_cnt_r[1:0] == CAPT_DIV4_LAST[1:0]);
        2'h3: event_r <= rise && (rise_cnt_r == CAPT_DIV16_LAST);
      endcase
    end
  end
endmodule
`default_nettype wire

// [pib_wb_slave.sv]
// classic wishbone slave feeding the register carrier
`timescale 1ns/1ns
`default_nettype none
module pib_wb_slave import pib_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  pib_reg_if.bus           rif
);
  logic req;

  assign req       = wb_cyc_i && wb_stb_i;
  assign rif.idx   = wb_adr_i[7:2];
  assign rif.wdata = wb_dat_i[7:0];
  // effects land on the edge where the master samples ack
  assign rif.wr    = req && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rif.rd    = req && wb_ack_o && !wb_we_i;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  // unmapped indices read as zero through the bank mux
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rif.rdata};
    end
  end
endmodule
`default_nettype wire

// [pib_periph_model.sv]
// behavioural timer units that feed the counter inputs of the flag bank
`timescale 1ns/1ns
`default_nettype none
module pib_periph_model import pib_pkg::*; #(
  parameter logic [7:0]  T12_START = 8'h01,
  parameter logic [15:0] T3_START  = 16'hFFF0
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic        pair_sel,
  input  wire logic        cap_sel,
  input  wire logic [7:0]  p1,
  input  wire logic [7:0]  p2,
  input  wire logic [15:0] p3,
  output var  logic [7:0]  t1,
  output var  logic [7:0]  t2,
  output var  logic [15:0] t3
);
  // nonzero restart values, so stopping a burst never looks like a rollover
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      t1 <= T12_START;
      t2 <= T12_START;
    end else if (pair_sel) begin
      {t2, t1} <= ({t2, t1} == {p2, p1}) ? 16'h0000 : {t2, t1} + 16'h0001;
    end else begin
      t1 <= (t1 == p1) ? 8'h00 : t1 + 8'h01;
      t2 <= (t2 == p2) ? 8'h00 : t2 + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      t3 <= T3_START;
    end else begin
      t3 <= (!cap_sel && t3 == p3) ? 16'h0000 : t3 + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [test_pib_irq_bank.sv]
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_pib_irq_bank import pib_pkg::*;;
  logic        ref_clk, rstn, cyc, stb, we, ack, irq, prd, sim, sid, run, pair_sel, cap_sel;
  logic [7:0]  adr, port, modes, p1, p2, t1, t2, lf, exp_head;
  logic [15:0] p3, t3;
  logic [31:0] wdat, rdat;
  logic [3:0]  caps, u;
  logic [4:0]  pls;
  logic [7:0]  expq[$];
  logic [7:0]  tab[6] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h20, 8'h00};
  int          n_errors, checks_done;

  pib_irq_bank i_pib_irq_bank (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .change_monitored_port(port), .port_read_pulse(prd), .timer1_count(t1), .timer2_count(t2), .timer3_count(t3),
    .timer1_period_value(p1), .timer2_period_value(p2), .timer3_period_value(p3), .capture1_pin(caps[0]),
    .capture2_pin(caps[1]), .capture3_pin(caps[2]), .capture4_pin(caps[3]), .capture_modes(modes),
    .usart1_tx_empty(u[0]), .usart1_rx_full(u[1]), .usart2_tx_empty(u[2]), .usart2_rx_full(u[3]),
    .serial_xfer_done(pls[0]), .serial_i2c_master(sim), .serial_seq_done(pls[1]), .serial_idle(sid),
    .serial_bus_start_stop(pls[2]), .serial_bus_collision(pls[3]), .converter_done(pls[4]),
    .timer_pair_select(pair_sel), .capture1_or_period_select(cap_sel), .irq_req_r(irq));

  pib_periph_model i_pib_periph_model (.ref_clk(ref_clk), .rstn(rstn), .run(run), .pair_sel(pair_sel),
    .cap_sel(cap_sel), .p1(p1), .p2(p2), .p3(p3), .t1(t1), .t2(t2), .t3(t3));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one classic cycle; pl fires a converter event in the cycle that the write lands
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic pl);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h000000, d};
    @(posedge ref_clk);
    if (pl) pls[4] <= 1'b1;
    n = 0;
    while (ack !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) n_errors++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (pl) pls[4] <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    expq.push_back(e);
    xfer(1'b0, idx, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 1'b0);
  endtask

  task automatic pulse(input int b);
    @(posedge ref_clk);
    pls[b] <= 1'b1;
    @(posedge ref_clk);
    pls[b] <= 1'b0;
  endtask

  // burst of timer activity from fresh counts, then read the first flag register
  task automatic trun(input logic [7:0] c, input int n, input logic [7:0] e);
    wr(IDX_CTRL, c);
    wr(IDX_FLAGS1, 8'h00);
    @(posedge ref_clk);
    run <= 1'b1;
    repeat (n) @(posedge ref_clk);
    run <= 1'b0;
    rd(IDX_FLAGS1, e | 8'h02);
  endtask

  // read data is judged at the ack edge against the oldest note
  always @(posedge ref_clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        n_errors++;
      end else begin
        exp_head = expq.pop_front();
        `CHK(rdat, {24'h000000, exp_head})
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; prd = 1'b0; sim = 1'b0;
    sid = 1'b0; run = 1'b0; port = 8'h00; modes = 8'h55; caps = 4'h0; u = 4'h5; pls = 5'h00;
    p1 = 8'h05; p2 = 8'h03; p3 = 16'h0007; lf = 8'h17; n_errors = 0; checks_done = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(IDX_FLAGS1, FLAGS1_RST);
    rd(IDX_FLAGS2, FLAGS2_RST);
    rd(IDX_ENABLE2, ENABLE_RST);
    rd(IDX_ENABLE1, ENABLE_RST);
    rd(IDX_CTRL, CTRL_RST);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(IDX_ENABLE2, 8'hFF);
    rd(IDX_ENABLE2, 8'hEF);
    wr(IDX_FLAGS2, 8'hFF);
    rd(IDX_FLAGS2, 8'hEE);
    `CHK(irq, 1'b1)
    wr(IDX_FLAGS2, 8'h00);
    // usart2 transmit mirror stays high, so the usart2 enables go off before the request checks
    wr(IDX_ENABLE2, 8'hEC);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    // serial, collision and converter sources, last case is a collision outside master mode
    for (int k = 0; k < 6; k++) begin
      sim <= (k == 1 || k == 3);
      sid <= (k == 2);
      pulse(k == 5 ? 3 : k);
      rd(IDX_FLAGS2, tab[k] | 8'h02);
      `CHK(irq, tab[k] != 8'h00)
      wr(IDX_FLAGS2, 8'h00);
    end
    xfer(1'b1, IDX_FLAGS2, 8'h00, 1'b1);
    rd(IDX_FLAGS2, 8'h22);
    wr(IDX_ENABLE2, 8'hCC);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(IDX_FLAGS2, 8'h00);
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      u <= lf[3:0];
      wr(IDX_FLAGS1, lf);
      rd(IDX_FLAGS1, (lf & FLAGS1_SW_MASK) | {6'h00, lf[0], lf[1]});
      rd(IDX_FLAGS2, {6'h00, lf[2], lf[3]});
    end
    u <= 4'h5;
    wr(IDX_FLAGS1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      modes <= k ? 8'h00 : 8'h55;
      caps <= k ? 4'h0 : 4'hF;
      repeat (8) @(posedge ref_clk);
      rd(IDX_FLAGS1, 8'h0E);
      rd(IDX_FLAGS2, 8'h0E);
      wr(IDX_FLAGS1, 8'h00);
      wr(IDX_FLAGS2, 8'h00);
    end
    // every fourth rise counts; the rise of the first capture pass is the first
    modes <= 8'hAA;
    for (int k = 0; k < 6; k++) begin
      caps <= (k % 2) ? 4'h0 : 4'hF;
      repeat (6) @(posedge ref_clk);
      if (k == 3) rd(IDX_FLAGS1, 8'h02);
    end
    rd(IDX_FLAGS1, 8'h0E);
    rd(IDX_FLAGS2, 8'h0E);
    wr(IDX_FLAGS1, 8'h00);
    wr(IDX_FLAGS2, 8'h00);
    port <= 8'hA5;
    repeat (8) @(posedge ref_clk);
    wr(IDX_FLAGS1, 8'h00);
    rd(IDX_FLAGS1, 8'h82);
    @(posedge ref_clk);
    prd <= 1'b1;
    @(posedge ref_clk);
    prd <= 1'b0;
    wr(IDX_FLAGS1, 8'h00);
    rd(IDX_FLAGS1, 8'h02);
    trun(8'h00, 20, 8'h30);
    trun(8'h00, 40, 8'h70);
    trun(8'h03, 40, 8'h40);
    trun(8'h01, 600, 8'h70);
    results();
  end
endmodule
`default_nettype wire
